// ### rtl/dsp_regs_pkg.sv
// Purpose: constants, field layouts and carriers for the core register file
// Assumes: byte offsets on a 256-byte APB window, one 32-bit word per register
// Notes: reset values and masks without a documented figure are plain defaults
`default_nettype none

package dsp_regs_pkg;

    // ========================================================================
    // register map (byte offsets)
    // ========================================================================
    localparam logic [7:0] DATA_BASE = 8'h00;  // x0 x1 y0 y1 a0 a1 b0 b1
    localparam logic [7:0] EXT_BASE = 8'h20;   // accum_a_ext, accum_b_ext
    localparam logic [7:0] ACC_BASE = 8'h28;   // full accumulator a, b
    localparam logic [7:0] STATUS_OFF = 8'h30;
    localparam logic [7:0] MODE_BYTE_OFF = 8'h34;
    localparam logic [7:0] FLAGS_BYTE_OFF = 8'h38;
    localparam logic [7:0] OPMODE_OFF = 8'h3C;
    localparam logic [7:0] VBASE_OFF = 8'h40;
    localparam logic [7:0] LCOUNT_OFF = 8'h44;
    localparam logic [7:0] LEND_OFF = 8'h48;
    localparam logic [7:0] SSIZE_OFF = 8'h4C;
    localparam logic [7:0] STOP_HIGH_OFF = 8'h50;
    localparam logic [7:0] STOP_LOW_OFF = 8'h54;
    localparam logic [7:0] SPTR_OFF = 8'h58;
    localparam logic [7:0] PCOUNT_OFF = 8'h5C;
    localparam logic [7:0] MEMFMT_OFF = 8'h60;
    localparam logic [7:0] AGU_BASE = 8'h80;   // pointers, offsets, modifiers
    localparam int DATA_REGS = 8;
    localparam int AGU_REGS = 24;
    localparam int STACK_DEPTH = 16;

    // ========================================================================
    // field positions
    // ========================================================================
    localparam int SR_LIMIT_BIT = 6;       // latched limit flag, flags byte
    localparam int SR_SCALE0_BIT = 10;     // scaling_select_bit0
    localparam int SR_SCALE1_BIT = 11;     // scaling_select_bit1
    localparam int SR_SIXTEEN_BIT = 17;    // sixteen-bit mode, extended mode byte
    localparam int FMT_BYTE_BIT = 0;       // memory operand is a byte
    localparam int FMT_SIGN_BIT = 1;       // byte is sign extended

    // ========================================================================
    // reset values, masks and saturation constants
    // ========================================================================
    localparam logic [23:0] STATUS_RST = 24'h000000;
    localparam logic [23:0] OPMODE_RST = 24'h000000;
    localparam logic [23:0] OPMODE_MASK = 24'hFFFFFF;
    localparam logic [23:0] VBASE_MASK = 24'hFFFF00;
    localparam logic [23:0] SAT_POS24 = 24'h7FFFFF;
    localparam logic [23:0] SAT_NEG24 = 24'h800000;
    localparam logic [15:0] SAT_POS16 = 16'h7FFF;
    localparam logic [15:0] SAT_NEG16 = 16'h8000;

    // ========================================================================
    // carriers
    // ========================================================================
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic push_call;
        logic push_loop;
        logic pop_call;
        logic pop_loop;
    } stack_cmd_t;

    typedef struct packed {
        logic [23:0] x_word;
        logic [23:0] y_word;
    } mem_in_t;

    typedef struct packed {
        logic [47:0] long_x;
        logic [47:0] long_y;
        logic [55:0] acc_a;
        logic [55:0] acc_b;
        logic [23:0] x_data_path;
        logic [23:0] y_data_path;
        logic [23:0] status_word;
        logic [23:0] operating_mode_word;
    } view_t;

endpackage : dsp_regs_pkg

`default_nettype wire

// ### rtl/dsp_core_register_file.sv
// Purpose: programmer-visible register file of a 24-bit dsp core over APB
// Assumes: APB4 slave, one wait state, byte lanes via pstrb on status and operating mode words only
// Notes: stack push/pop come from the core as one-cycle pulses
//
// Function
// - eight 24-bit data registers, long uses pairs
// - 24-bit mode: lsb bit 0, msb 23/47
// - sixteen mode: lsb bit 8, ignore 0-7
// - sixteen mode: 16-bit data, 32/40-bit groups
// - extension read: low byte, sign above
// - extension write keeps only low byte
// - accumulator is ext:middle:low, msb bit 55
// - accumulator read passes status scaling shifter
// - extension in use saturates word destination
// - individual accumulator parts never saturate
// - saturation sets latched limit flag
// - word into accumulator: sign extend, zero low
// - middle word write touches only itself
// - 24 address registers, 24 bits each
// - mode word: chip, extended, stack bytes
// - undefined mode/vector bits read zero; OPMODE_MASK keeps all 24 mode bits, so only vector bits 0-7 read zero
// - status word bytes, mode/flags individually
// - status and mode take 8/16/24-bit data
// - loop and stack registers 24-bit words
// - stack entries 48 bits: pc:sr or la:lc
// - sixteen mode: memory words in low part
// - memory bytes zero or sign extended
`default_nettype none

module dsp_core_register_file (
    input wire logic clk,
    input wire logic rst,
    input wire dsp_regs_pkg::apb_req_t apb_req,
    output dsp_regs_pkg::apb_rsp_t apb_rsp,
    input wire dsp_regs_pkg::stack_cmd_t stack_cmd,
    input wire dsp_regs_pkg::mem_in_t mem_in,
    output dsp_regs_pkg::view_t view
);

    // ========================================================================
    // state
    // ========================================================================
    typedef struct packed {
        logic [dsp_regs_pkg::DATA_REGS-1:0][23:0] data;
        logic [1:0][7:0] ext;
        logic [dsp_regs_pkg::AGU_REGS-1:0][23:0] agu;
        logic [dsp_regs_pkg::STACK_DEPTH-1:0][47:0] stk;

        // control words
        logic [23:0] status_word;
        logic [23:0] operating_mode_word;
        logic [23:0] vector_base;
        logic [23:0] loop_count;
        logic [23:0] loop_end_addr;
        logic [23:0] stack_size_word;
        logic [23:0] stack_pointer;
        logic [23:0] program_counter;

        // memory format, bus response and views
        logic [1:0] mem_fmt;
        logic ack;
        logic err;
        logic [31:0] rdata;
        dsp_regs_pkg::view_t view;
    } state_t;

    state_t s;
    state_t next_s;

    // ========================================================================
    // helpers
    // ========================================================================
    function automatic logic [55:0] scale(input logic [55:0] v, input logic [1:0] m);
        logic [55:0] r;
        r = v;

        unique case (m)
            2'b01: r = {v[55], v[55:1]};
            2'b10: r = {v[54:0], 1'b0};
            default: r = v;
        endcase
        return r;
    endfunction : scale

    function automatic logic [23:0] mem_format(input logic [23:0] w, input logic [1:0] fmt,
                                               input logic sixteen);
        logic [23:0] r;
        r = w;

        if (fmt[dsp_regs_pkg::FMT_BYTE_BIT]) begin
            if (fmt[dsp_regs_pkg::FMT_SIGN_BIT]) begin
                r = {{16{w[7]}}, w[7:0]};
            end else begin
                r = {16'h0000, w[7:0]};
            end
        end else if (sixteen) begin
            r = {w[15:0], 8'h00};
        end
        return r;
    endfunction : mem_format

    // ========================================================================
    // decode
    // ========================================================================
    logic access;
    logic sixteen;
    logic [7:0] addr;

    logic [7:0] agu_ofs;
    logic [4:0] agu_idx;
    logic [2:0] data_idx;
    logic acc_idx;

    logic is_data;
    logic is_ext;
    logic is_acc;
    logic is_agu;
    logic hit;

    // accumulator read path
    logic [55:0] acc_sel;
    logic [55:0] scaled;
    logic ext_in_use;
    logic [23:0] acc_word;
    logic [31:0] rd_val;

    logic [3:0] sp_idx;
    logic [3:0] sp_up;

    logic [31:0] wd;

    always_comb begin
        addr = apb_req.paddr;
        wd = apb_req.pwdata;
        access = apb_req.psel & apb_req.penable;
        sixteen = s.status_word[dsp_regs_pkg::SR_SIXTEEN_BIT];
        agu_ofs = addr - dsp_regs_pkg::AGU_BASE;
        agu_idx = agu_ofs[6:2];
        data_idx = addr[4:2];
        acc_idx = addr[2];

        is_data = addr < dsp_regs_pkg::EXT_BASE;
        is_ext = (addr[7:3] == dsp_regs_pkg::EXT_BASE[7:3]) && !addr[2];
        is_acc = (addr == dsp_regs_pkg::ACC_BASE)
              || (addr == dsp_regs_pkg::ACC_BASE + 8'h04);
        is_ext = is_ext || (addr == dsp_regs_pkg::EXT_BASE + 8'h04);
        is_agu = (addr >= dsp_regs_pkg::AGU_BASE)
              && (agu_idx < 5'(dsp_regs_pkg::AGU_REGS));

        sp_idx = s.stack_pointer[3:0];
        sp_up = sp_idx + 4'h1;

        // full accumulator read path: scale, then limit
        acc_sel = acc_idx ? {s.ext[1], s.data[7], s.data[6]}
                          : {s.ext[0], s.data[5], s.data[4]};
        scaled = scale(acc_sel, {s.status_word[dsp_regs_pkg::SR_SCALE1_BIT],
                                 s.status_word[dsp_regs_pkg::SR_SCALE0_BIT]});
        ext_in_use = !((&scaled[55:47]) || !(|scaled[55:47]));

        if (sixteen) begin
            acc_word = {8'h00, scaled[47:32]};
            if (ext_in_use) begin
                acc_word = {8'h00, scaled[55] ? dsp_regs_pkg::SAT_NEG16
                                              : dsp_regs_pkg::SAT_POS16};
            end
        end else begin
            acc_word = scaled[47:24];
            if (ext_in_use) begin
                acc_word = scaled[55] ? dsp_regs_pkg::SAT_NEG24
                                      : dsp_regs_pkg::SAT_POS24;
            end
        end

        // read mux
        hit = apb_req.paddr[1:0] == 2'b00;
        rd_val = 32'h00000000;
        if (is_data) begin
            // parts of an accumulator are plain words, never limited
            rd_val = sixteen ? {16'h0000, s.data[data_idx][23:8]}
                             : {8'h00, s.data[data_idx]};
        end else if (is_ext) begin
            rd_val = {8'h00, {16{s.ext[acc_idx][7]}}, s.ext[acc_idx]};
        end else if (is_acc) begin
            rd_val = {8'h00, acc_word};
        end else if (is_agu) begin
            rd_val = {8'h00, s.agu[agu_idx]};
        end else begin
            unique case (addr)
                dsp_regs_pkg::STATUS_OFF: rd_val = {8'h00, s.status_word};
                dsp_regs_pkg::MODE_BYTE_OFF: rd_val = {24'h000000, s.status_word[15:8]};
                dsp_regs_pkg::FLAGS_BYTE_OFF: rd_val = {24'h000000, s.status_word[7:0]};
                dsp_regs_pkg::OPMODE_OFF: rd_val = {8'h00, s.operating_mode_word};
                dsp_regs_pkg::VBASE_OFF: rd_val = {8'h00, s.vector_base};
                dsp_regs_pkg::LCOUNT_OFF: rd_val = {8'h00, s.loop_count};
                dsp_regs_pkg::LEND_OFF: rd_val = {8'h00, s.loop_end_addr};
                dsp_regs_pkg::SSIZE_OFF: rd_val = {8'h00, s.stack_size_word};
                dsp_regs_pkg::STOP_HIGH_OFF: rd_val = {8'h00, s.stk[sp_idx][47:24]};
                dsp_regs_pkg::STOP_LOW_OFF: rd_val = {8'h00, s.stk[sp_idx][23:0]};
                dsp_regs_pkg::SPTR_OFF: rd_val = {8'h00, s.stack_pointer};
                dsp_regs_pkg::PCOUNT_OFF: rd_val = {8'h00, s.program_counter};
                dsp_regs_pkg::MEMFMT_OFF: rd_val = {30'h00000000, s.mem_fmt};
                default: hit = 1'b0;
            endcase
        end

        // holes in the control block
        if (!(is_data || is_ext || is_acc || is_agu)) begin
            hit = hit && (rd_val != 32'h00000000 || addr == dsp_regs_pkg::STATUS_OFF
                  || addr == dsp_regs_pkg::MODE_BYTE_OFF || addr == dsp_regs_pkg::FLAGS_BYTE_OFF
                  || addr == dsp_regs_pkg::OPMODE_OFF || addr == dsp_regs_pkg::VBASE_OFF
                  || addr == dsp_regs_pkg::LCOUNT_OFF || addr == dsp_regs_pkg::LEND_OFF
                  || addr == dsp_regs_pkg::SSIZE_OFF || addr == dsp_regs_pkg::STOP_HIGH_OFF
                  || addr == dsp_regs_pkg::STOP_LOW_OFF || addr == dsp_regs_pkg::SPTR_OFF
                  || addr == dsp_regs_pkg::PCOUNT_OFF || addr == dsp_regs_pkg::MEMFMT_OFF);
        end
    end

    // ========================================================================
    // next state
    // ========================================================================
    always_comb begin
        next_s = s;

        // one wait state: data is prepared in the first access cycle
        next_s.ack = access && !s.ack;
        if (access && !s.ack) begin
            next_s.rdata = (hit && !apb_req.pwrite) ? rd_val : 32'h00000000;
            next_s.err = !hit;
        end

        // writes take effect on the completing edge only
        if (access && s.ack && apb_req.pwrite && !s.err) begin
            if (is_data) begin
                next_s.data[data_idx] = sixteen ? {wd[15:0], 8'h00}
                                                : wd[23:0];
            end else if (is_ext) begin
                next_s.ext[acc_idx] = wd[7:0];
            end else if (is_acc) begin
                if (sixteen) begin
                    next_s.ext[acc_idx] = {8{wd[15]}};
                    next_s.data[{1'b1, acc_idx, 1'b1}] = {wd[15:0], 8'h00};
                end else begin
                    next_s.ext[acc_idx] = {8{wd[23]}};
                    next_s.data[{1'b1, acc_idx, 1'b1}] = wd[23:0];
                end
                next_s.data[{1'b1, acc_idx, 1'b0}] = 24'h000000;
            end else if (is_agu) begin
                next_s.agu[agu_idx] = wd[23:0];
            end else begin
                unique case (addr)
                    dsp_regs_pkg::STATUS_OFF: begin
                        for (int b = 0; b < 3; b++) begin
                            if (apb_req.pstrb[b]) begin
                                next_s.status_word[b*8 +: 8] = wd[b*8 +: 8];
                            end
                        end
                    end
                    dsp_regs_pkg::MODE_BYTE_OFF: next_s.status_word[15:8] = wd[7:0];
                    dsp_regs_pkg::FLAGS_BYTE_OFF: next_s.status_word[7:0] = wd[7:0];
                    dsp_regs_pkg::OPMODE_OFF: begin
                        for (int b = 0; b < 3; b++) begin
                            if (apb_req.pstrb[b]) begin
                                next_s.operating_mode_word[b*8 +: 8] = wd[b*8 +: 8]
                                    & dsp_regs_pkg::OPMODE_MASK[b*8 +: 8];
                            end
                        end
                    end
                    dsp_regs_pkg::VBASE_OFF: begin
                        next_s.vector_base = wd[23:0] & dsp_regs_pkg::VBASE_MASK;
                    end
                    dsp_regs_pkg::LCOUNT_OFF: next_s.loop_count = wd[23:0];
                    dsp_regs_pkg::LEND_OFF: next_s.loop_end_addr = wd[23:0];
                    dsp_regs_pkg::SSIZE_OFF: next_s.stack_size_word = wd[23:0];
                    dsp_regs_pkg::STOP_HIGH_OFF: next_s.stk[sp_idx][47:24] = wd[23:0];
                    dsp_regs_pkg::STOP_LOW_OFF: next_s.stk[sp_idx][23:0] = wd[23:0];
                    dsp_regs_pkg::SPTR_OFF: next_s.stack_pointer = wd[23:0];
                    dsp_regs_pkg::PCOUNT_OFF: next_s.program_counter = wd[23:0];
                    dsp_regs_pkg::MEMFMT_OFF: next_s.mem_fmt = wd[1:0];
                    default: next_s.mem_fmt = s.mem_fmt;
                endcase
            end
        end

        // core stack traffic; a push and pop together cancel to a push
        // index wraps, no overflow check
        if (stack_cmd.push_call) begin
            next_s.stk[sp_up] = {s.program_counter, s.status_word};
            next_s.stack_pointer = s.stack_pointer + 24'h000001;
        end else if (stack_cmd.push_loop) begin
            next_s.stk[sp_up] = {s.loop_end_addr, s.loop_count};
            next_s.stack_pointer = s.stack_pointer + 24'h000001;
        end else if (stack_cmd.pop_call) begin
            next_s.program_counter = s.stk[sp_idx][47:24];
            next_s.status_word = s.stk[sp_idx][23:0];
            next_s.stack_pointer = s.stack_pointer - 24'h000001;
        end else if (stack_cmd.pop_loop) begin
            next_s.loop_end_addr = s.stk[sp_idx][47:24];
            next_s.loop_count = s.stk[sp_idx][23:0];
            next_s.stack_pointer = s.stack_pointer - 24'h000001;
        end

        // limit flag set last so it wins over a pop_call status restore
        if (access && !s.ack && !apb_req.pwrite && is_acc && ext_in_use && hit) begin
            next_s.status_word[dsp_regs_pkg::SR_LIMIT_BIT] = 1'b1;
        end

        // operand views toward the data path
        next_s.view.long_x = sixteen ? {16'h0000, s.data[1][23:8], s.data[0][23:8]}
                                     : {s.data[1], s.data[0]};
        next_s.view.long_y = sixteen ? {16'h0000, s.data[3][23:8], s.data[2][23:8]}
                                     : {s.data[3], s.data[2]};

        next_s.view.acc_a = sixteen ? {s.ext[0], s.data[5], s.data[4][23:8], 8'h00}
                                    : {s.ext[0], s.data[5], s.data[4]};
        next_s.view.acc_b = sixteen ? {s.ext[1], s.data[7], s.data[6][23:8], 8'h00}
                                    : {s.ext[1], s.data[7], s.data[6]};

        next_s.view.x_data_path = mem_format(mem_in.x_word, s.mem_fmt, sixteen);
        next_s.view.y_data_path = mem_format(mem_in.y_word, s.mem_fmt, sixteen);
        next_s.view.status_word = s.status_word;
        next_s.view.operating_mode_word = s.operating_mode_word;
    end

    // ========================================================================
    // registers
    // ========================================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.status_word <= dsp_regs_pkg::STATUS_RST;
            s.operating_mode_word <= dsp_regs_pkg::OPMODE_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flops, pslverr the and of ack and err
    assign apb_rsp.prdata = s.rdata;
    assign apb_rsp.pready = s.ack;
    assign apb_rsp.pslverr = s.ack && s.err;
    assign view = s.view;

endmodule : dsp_core_register_file

`default_nettype wire

// ### tb/dsp_regs_checker_asserts.sv
// Purpose: port-level assertions for the core register file
// Assumes: one wait state per APB access, views lag by one cycle
// Notes: attached by the bind below the module
`default_nettype none

module dsp_regs_checker (
    input wire logic clk,
    input wire logic rst,
    input wire dsp_regs_pkg::apb_req_t apb_req,
    input wire dsp_regs_pkg::apb_rsp_t apb_rsp,
    input wire dsp_regs_pkg::stack_cmd_t stack_cmd,
    input wire dsp_regs_pkg::mem_in_t mem_in,
    input wire dsp_regs_pkg::view_t view
);
    // ====================================================================
    // helpers
    // ====================================================================
    logic acc;
    logic rd_ok;
    logic wr_sr;
    logic pop;
    assign acc = apb_req.psel && apb_req.penable;
    assign rd_ok = apb_rsp.pready && !apb_req.pwrite && !apb_rsp.pslverr;
    assign wr_sr = acc && apb_req.pwrite && (apb_req.paddr == dsp_regs_pkg::STATUS_OFF
        || apb_req.paddr == dsp_regs_pkg::FLAGS_BYTE_OFF);
    assign pop = stack_cmd.pop_call || stack_cmd.pop_loop;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_start;
        $rose(apb_req.penable) && apb_req.psel;
    endsequence
    sequence s_wait_ready;
        !apb_rsp.pready ##1 apb_rsp.pready;
    endsequence
    // ====================================================================
    // assertions
    // ====================================================================
    a_one_wait: assert property (s_start |-> s_wait_ready)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (apb_rsp.pready |-> acc ##1 !apb_rsp.pready)
        else $error("ready outside access or longer than one cycle");
    a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error without ready");
    a_misalign_err: assert property (apb_rsp.pready && apb_req.paddr[1:0] != 2'h0
        |-> apb_rsp.pslverr) else $error("misaligned access not refused");
    a_err_rdzero: assert property (apb_rsp.pslverr && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
        else $error("refused read returned data");
    a_ext_sign: assert property (
        rd_ok && apb_req.paddr == dsp_regs_pkg::EXT_BASE
        |-> apb_rsp.prdata[23:8] == {16{apb_rsp.prdata[7]}}) else $error("extension not sign filled");
    a_vbase_low: assert property (
        rd_ok && apb_req.paddr == dsp_regs_pkg::VBASE_OFF |-> apb_rsp.prdata[7:0] == 8'h00)
        else $error("vector base low bits not zero");
    a_word_width: assert property (rd_ok |-> apb_rsp.prdata[31:24] == 8'h00)
        else $error("read data wider than a word");
    a_mem_format: assert property (
        !$past(rst) && !$past(rst, 2) |-> view.x_data_path == $past(mem_in.x_word)
        || view.x_data_path == {$past(mem_in.x_word[15:0]), 8'h00}
        || view.x_data_path == {16'h0000, $past(mem_in.x_word[7:0])}
        || view.x_data_path == {{16{$past(mem_in.x_word[7])}}, $past(mem_in.x_word[7:0])})
        else $error("memory word formatted wrongly");
    a_limit_hold: assert property (
        $fell(view.status_word[dsp_regs_pkg::SR_LIMIT_BIT]) && !$past(rst)
        |-> $past(wr_sr, 1) || $past(wr_sr, 2) || $past(wr_sr, 3) || $past(pop, 1)
        || $past(pop, 2) || $past(pop, 3)) else $error("limit flag dropped by itself");
endmodule : dsp_regs_checker

bind dsp_core_register_file dsp_regs_checker dsp_regs_checker_i (.clk(clk), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .stack_cmd(stack_cmd), .mem_in(mem_in), .view(view));

`default_nettype wire

// ### tb/dsp_core_register_file_test.sv
// Purpose: self-checking bench for the core register file
// Assumes: APB master with bounded waits, views checked after their lag
// Notes: one task per scenario
`default_nettype none

module dsp_core_register_file_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    dsp_regs_pkg::apb_req_t req = '0;
    dsp_regs_pkg::apb_rsp_t rsp;
    dsp_regs_pkg::stack_cmd_t scmd = '0;
    dsp_regs_pkg::mem_in_t mem = '0;
    dsp_regs_pkg::view_t view;
    int failures = 0;
    int cmp_count = 0;
    logic [31:0] rdat;
    logic rerr;
    always #2.5 clk = ~clk;
    dsp_core_register_file dsp_core_register_file_i (.clk(clk), .rst(rst), .apb_req(req),
        .apb_rsp(rsp), .stack_cmd(scmd), .mem_in(mem), .view(view));
    // ====================================================================
    // shared tasks
    // ====================================================================
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic results;
        $display("failures=%0d compares=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // idle cycle before setup keeps each strobe change in its own time step
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            results();
        end
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, 4'hF);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0, 4'hF);
        chk(rdat, e);
    endtask : rd
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle
    task automatic pulse(input logic [3:0] c);
        @(posedge clk);
        scmd <= c;
        @(posedge clk);
        scmd <= '0;
    endtask : pulse
    // ====================================================================
    // scenarios
    // ====================================================================
    task automatic t_accum;
        wr(8'h20, 32'h00ABCD80);
        rd(8'h20, 32'h00FFFF80);
        wr(8'h28, 32'h00876543);
        settle();
        chk(view.acc_a, 56'hFF876543000000);
        rd(8'h28, 32'h00876543);
        wr(8'h14, 32'h00123456);
        settle();
        chk(view.acc_a, 56'hFF123456000000);
        rd(8'h14, 32'h00123456);
        rd(8'h28, 32'h00800000);
        rd(8'h30, 32'h00000040);
        rd(8'h38, 32'h00000040);
        wr(8'h30, 32'h0);
        rd(8'h30, 32'h0);
        wr(8'h2C, 32'h00000001);
        settle();
        chk(view.acc_b, 56'h00000001000000);
        rd(8'h2C, 32'h00000001);
    endtask : t_accum
    task automatic t_scale;
        wr(8'h28, 32'h00400000);
        wr(8'h30, 32'h00000800);
        rd(8'h28, 32'h007FFFFF);
        rd(8'h30, 32'h00000840);
        wr(8'h30, 32'h00000400);
        rd(8'h28, 32'h00200000);
        wr(8'h30, 32'h0);
    endtask : t_scale
    task automatic t_sixteen;
        wr(8'h00, 32'h00111111);
        wr(8'h04, 32'h00222222);
        wr(8'h0C, 32'h00333333);
        settle();
        chk(view.long_x, 48'h222222111111);
        chk(view.long_y, 48'h333333000000);
        wr(8'h30, 32'h00020000);
        wr(8'h00, 32'h0000ABCD);
        rd(8'h00, 32'h0000ABCD);
        mem.x_word <= 24'h001234;
        settle();
        chk(view.long_x, 48'h00002222ABCD);
        chk(view.x_data_path, 24'h123400);
        wr(8'h30, 32'h0);
    endtask : t_sixteen
    task automatic t_regs;
        xfer(8'h3C, 1'b1, 32'h00A5C3E7, 4'b0010);
        rd(8'h3C, 32'h0000C300);
        wr(8'h3C, 32'h00A5C3E7);
        settle();
        chk(view.operating_mode_word, 24'hA5C3E7);
        wr(8'h40, 32'h00FFFFFF);
        rd(8'h40, 32'h00FFFF00);
        for (int i = 0; i < 24; i++) wr(8'h80 + 8'(4 * i), 32'h00C00000 + 32'(i));
        for (int i = 0; i < 24; i++) rd(8'h80 + 8'(4 * i), 32'h00C00000 + 32'(i));
    endtask : t_regs
    task automatic t_stack;
        wr(8'h5C, 32'h0000ABC1);
        wr(8'h30, 32'h00000003);
        pulse(4'h8);
        rd(8'h58, 32'h1);
        rd(8'h50, 32'h0000ABC1);
        rd(8'h54, 32'h3);
        wr(8'h48, 32'h00000777);
        wr(8'h44, 32'h00000009);
        pulse(4'h4);
        rd(8'h50, 32'h00000777);
        rd(8'h54, 32'h9);
        wr(8'h44, 32'h0);
        pulse(4'h1);
        rd(8'h58, 32'h1);
        rd(8'h44, 32'h9);
        wr(8'h5C, 32'h0);
        wr(8'h30, 32'h0);
        pulse(4'h2);
        rd(8'h5C, 32'h0000ABC1);
        settle();
        chk(view.status_word, 24'h000003);
        wr(8'h30, 32'h0);
    endtask : t_stack
    task automatic t_mem;
        wr(8'h60, 32'h3);
        mem.x_word <= 24'h0000F5;
        mem.y_word <= 24'h000080;
        settle();
        chk(view.x_data_path, 24'hFFFFF5);
        chk(view.y_data_path, 24'hFFFF80);
        wr(8'h60, 32'h1);
        settle();
        chk(view.x_data_path, 24'h0000F5);
        wr(8'h60, 32'h0);
        settle();
        chk(view.x_data_path, 24'h0000F5);
    endtask : t_mem
    task automatic t_refuse;
        xfer(8'h64, 1'b0, 32'h0, 4'hF);
        chk({rerr, rdat}, {1'b1, 32'h0});
        xfer(8'h02, 1'b0, 32'h0, 4'hF);
        chk(rerr, 1'b1);
    endtask : t_refuse
    // ====================================================================
    // main sequence
    // ====================================================================
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_accum();
        t_scale();
        t_sixteen();
        t_regs();
        t_stack();
        t_mem();
        t_refuse();
        results();
    end
endmodule : dsp_core_register_file_test

`default_nettype wire
